/* File: include/dbpc_defines.vh */
// register offsets, field positions and timing counts of the dma bus-cycle and priority block
`ifndef DBPC_DEFINES_VH
`define DBPC_DEFINES_VH
`define DBPC_OFF_CTRL0A  8'h00
`define DBPC_OFF_CTRL0B  8'h04
`define DBPC_OFF_CTRL1A  8'h08
`define DBPC_OFF_CTRL1B  8'h0C
`define DBPC_OFF_MODE    8'h10
`define DBPC_OFF_COUNT0A 8'h14
`define DBPC_OFF_COUNT0B 8'h18
`define DBPC_OFF_COUNT1A 8'h1C
`define DBPC_OFF_COUNT1B 8'h20
`define DBPC_OFF_STATUS  8'h24
`define DBPC_BIT_CHEN    0
`define DBPC_BIT_MEN     1
`define DBPC_BIT_IRQEN   2
`define DBPC_BIT_EXTREQ  3
`define DBPC_BIT_LEVEL   4
`define DBPC_BIT_BURST   5
`define DBPC_BIT_BLOCK   6
`define DBPC_BIT_INTSRC  7
`define DBPC_MODE_FULL0  0
`define DBPC_MODE_FULL1  1
`define DBPC_REQ_WAIT_NS 40
`define DBPC_CLK_NS      10
`define DBPC_REQ_WAIT    ((`DBPC_REQ_WAIT_NS + `DBPC_CLK_NS - 1) / `DBPC_CLK_NS)
`define DBPC_CTRL_RESET  8'h00
`endif

/* File: hw/dbpc_core.v */
// dma bus-cycle sequencing, channel arbitration, suspend/abort and end-of-transfer interrupts
//
// Chosen here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "dbpc_defines.vh"

// Functional notes
// - dead state, then source read, destination write
// - hold bus over read-write pair
// - bus cycles obey area width, wait settings
// - level request keeps transferring while low
// - wait four states; resample after read
// - priority 0A,0B,1A,1B; full: 0 over 1
// - request bus; serve highest requester at grant
// - other channels pending until bus released
// - release after single, cycle-steal, external burst transfers
// - burst holds to end; block to block end
// - higher priority request releases after unit
// - external bus request or refresh yields bus
// - nmi ignored in short-address mode
// - full mode needs both enables; nmi clears master
// - normal full mode resumes when master reset
// - clearing enable halts after current unit
// - reset and standby initialize; sleep continues
// - one end interrupt line per channel, four in all
// - end irq when enable 0, irq enable 1
// - b-channel end irqs off in full mode
// - final count clears channel enable
// - internal source withheld from cpu while enabled
// - enabled but master off drops activations
module dbpc_core #(
  parameter REQ_WAIT = `DBPC_REQ_WAIT
) (
  // system
  input  wire        clk,
  input  wire        nrst,
  input  wire        standby,
  input  wire        nmi,
  // wishbone slave
  input  wire        wbCyc,
  input  wire        wbStb,
  input  wire        wbWe,
  input  wire [7:0]  wbAdr,
  input  wire [3:0]  wbSel,
  input  wire [31:0] wbDatW,
  output reg  [31:0] wbDatR,
  output reg         wbAck,
  // activation sources, one per channel 0A,0B,1A,1B
  input  wire [3:0]  transferRequest_n,
  input  wire [3:0]  internalReq,
  output wire [3:0]  internalReqToCpu,
  output wire [3:0]  internalReqTaken,
  // cpu bus arbitration
  output wire        busRequest,
  input  wire        busGrant,
  input  wire        external_bus_request_n,
  input  wire        refreshRequest,
  input  wire        higherMasterReq,
  // transfer cycles through the bus controller
  output reg         cycRead,
  output reg         cycWrite,
  output reg         cycDead,
  output reg  [1:0]  cycChannel,
  input  wire        cycDone,
  output reg         transferEnd_n,
  // end of transfer interrupts
  output wire        end_irq_ch0_a,
  output wire        end_irq_ch0_b,
  output wire        end_irq_ch1_a,
  output wire        end_irq_ch1_b
);

  localparam ST_IDLE  = 3'd0;
  localparam ST_REQ   = 3'd1;
  localparam ST_DEAD  = 3'd2;
  localparam ST_READ  = 3'd3;
  localparam ST_WRITE = 3'd4;
  // state codes: idle waits for a runnable pending channel,
  // req holds the bus request through the four-state wait,
  // dead is the single idle bus state after the grant,
  // read and write form one unit that keeps the bus
  // across both halves

  reg  [7:0]  ctrl [0:3];
  reg  [15:0] count [0:3];
  reg  [1:0]  fullMode;
  reg  [3:0]  pending;
  reg  [3:0]  reqPrev_n;
  reg  [2:0]  state;
  reg  [1:0]  active;
  reg  [3:0]  waitCnt;
  reg         sampleHold;
  reg  [3:0]  runnable;
  reg  [3:0]  newReq;
  reg         higherPend;
  reg  [1:0]  winner;
  reg         anyWin;
  reg         keepBus;
  reg  [31:0] next_rd;
  integer     i;

  // count register index from the byte address, low bits dropped
  wire [7:0]  cntOff = wbAdr - `DBPC_OFF_COUNT0A;
  wire [1:0]  cntIdx = cntOff[3:2];

  // a channel may run: short mode needs channel enable, full mode both
  // b channels of a full-mode pair never run on their own;
  // the master enable lives in the a register of the pair
  // a cleared enable stops the unit after the current write
  always @* begin
    for (i = 0; i < 4; i = i + 1) begin
      if (fullMode[i / 2]) begin
        runnable[i] = ctrl[i][`DBPC_BIT_CHEN] && ctrl[i & 2][`DBPC_BIT_MEN] && !i[0];
      end else begin
        runnable[i] = ctrl[i][`DBPC_BIT_CHEN];
      end
    end
  end

  // activation events per channel: edge, level or internal source
  // the pin is not looked at between the grant and the end
  // of the read; edge mode needs high then low on two edges
  // auto-request channels always ask
  always @* begin
    for (i = 0; i < 4; i = i + 1) begin
      if (ctrl[i][`DBPC_BIT_INTSRC]) begin
        newReq[i] = internalReq[i];
      end else if (!ctrl[i][`DBPC_BIT_EXTREQ]) begin
        newReq[i] = 1'b1; // auto-request
      end else if (ctrl[i][`DBPC_BIT_LEVEL]) begin
        newReq[i] = !transferRequest_n[i] && !sampleHold;
      end else begin
        newReq[i] = reqPrev_n[i] && !transferRequest_n[i] && !sampleHold;
      end
    end
  end

  // internal sources are never marked taken; internalReqTaken is held at zero
  assign internalReqTaken = internalReq & runnable & pending & ~pending; // no auto-clear flag here
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gIrq
      assign internalReqToCpu[g] = internalReq[g] &
        !(ctrl[g][`DBPC_BIT_INTSRC] && ctrl[g][`DBPC_BIT_CHEN]);
    end
  endgenerate

  // fixed priority pick, lowest index wins
  always @* begin
    winner = 2'd0;
    anyWin = 1'b0;
    for (i = 3; i >= 0; i = i - 1) begin
      if (pending[i] && runnable[i]) begin
        winner = i[1:0];
        anyWin = 1'b1;
      end
    end
  end

  // a higher-priority channel waits
  always @* begin
    higherPend = 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      if (i < active && pending[i] && runnable[i]) begin
        higherPend = 1'b1;
      end
    end
  end

  // decide whether the bus is kept after the current unit
  // short mode and cycle-steal give the bus back after each unit;
  // competing masters, refresh and higher channels force a release
  // as does the last unit of a transfer
  always @* begin
    keepBus = !fullMode[active / 2] ? 1'b0 :
              (ctrl[active][`DBPC_BIT_BURST] && !ctrl[active][`DBPC_BIT_EXTREQ]) ||
              ctrl[active][`DBPC_BIT_BLOCK];
    if (higherPend || higherMasterReq || !external_bus_request_n || refreshRequest) begin
      keepBus = 1'b0;
    end
    if (!runnable[active] || count[active] == 16'h0001) begin
      keepBus = 1'b0;
    end
  end

  // the request stands from the wait until the unit ends;
  // once granted it follows the grant so the arbiter stays in step
  assign busRequest = (state == ST_REQ) || ((state != ST_IDLE) && busGrant);

  // bus cycle sequencer
  // standby is treated as reset so nothing runs on after it
  // the grant is only taken once the wait count has run out,
  // which keeps a fast arbiter from shortening the wait
  // pending bits of the active channel are resampled at the
  // end of the read, so a level request keeps its channel busy
  // a burst goes straight from write back to read, no dead state
  always @(posedge clk) begin
    if (!nrst || standby) begin
      state         <= ST_IDLE;
      active        <= 2'd0;
      waitCnt       <= 4'h0;
      sampleHold    <= 1'b0;
      pending       <= 4'h0;
      reqPrev_n     <= 4'hF;
      cycRead       <= 1'b0;
      cycWrite      <= 1'b0;
      cycDead       <= 1'b0;
      cycChannel    <= 2'd0;
      transferEnd_n <= 1'b1;
    end else begin
      reqPrev_n <= transferRequest_n;
      // pending requests collect, masked by enables
      pending <= (pending | newReq) & runnable;
      case (state)
        ST_IDLE: begin
          if (anyWin) begin
            state   <= ST_REQ;
            waitCnt <= 4'h0;
          end
        end
        ST_REQ: begin
          if (waitCnt < REQ_WAIT[3:0]) begin
            waitCnt <= waitCnt + 4'h1;
          end
          if (!anyWin) begin
            state <= ST_IDLE;
          end else if (busGrant && waitCnt >= REQ_WAIT[3:0]) begin
            active     <= winner;
            cycChannel <= winner;
            cycDead    <= 1'b1;
            sampleHold <= 1'b1;
            state      <= ST_DEAD;
          end
        end
        ST_DEAD: begin
          cycDead <= 1'b0;
          cycRead <= 1'b1;
          state   <= ST_READ;
        end
        ST_READ: begin
          if (cycDone) begin
            cycRead    <= 1'b0;
            cycWrite   <= 1'b1;
            sampleHold <= 1'b0;
            pending[active] <= newReq[active];
            transferEnd_n <= !(count[active] == 16'h0001);
            state      <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (cycDone) begin
            cycWrite      <= 1'b0;
            transferEnd_n <= 1'b1;
            if (keepBus && runnable[active]) begin
              cycRead <= 1'b1;
              state   <= ST_READ;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // registers: control, mode, counts; hardware clears enables
  // a hardware clear of the channel enable at the final count
  // is written after the bus write, so it wins in the same cycle
  // nmi clears the master enable of full-mode pairs only;
  // short-mode channels carry no master enable
  // writes land on the edge where the strobe is first seen
  always @(posedge clk) begin
    if (!nrst || standby) begin
      for (i = 0; i < 4; i = i + 1) begin
        ctrl[i]  <= `DBPC_CTRL_RESET;
        count[i] <= 16'h0000;
      end
      fullMode <= 2'b00;
    end else begin
      if (wbCyc && wbStb && wbWe && !wbAck) begin
        if (wbAdr == `DBPC_OFF_MODE && wbSel[0]) begin
          fullMode <= wbDatW[1:0];
        end else if (wbAdr[7:4] == 4'h0 && wbSel[0]) begin
          ctrl[wbAdr[3:2]] <= wbDatW[7:0];
        end else if (wbAdr >= `DBPC_OFF_COUNT0A && wbAdr <= `DBPC_OFF_COUNT1B) begin
          if (wbSel[0]) count[cntIdx] <= {count[cntIdx][15:8], wbDatW[7:0]};
          if (wbSel[1]) count[cntIdx] <= {wbDatW[15:8], wbSel[0] ? wbDatW[7:0] : count[cntIdx][7:0]};
        end
      end
      if (state == ST_WRITE && cycDone) begin
        count[active] <= count[active] - 16'h0001;
        if (count[active] == 16'h0001) begin
          ctrl[active][`DBPC_BIT_CHEN] <= 1'b0;
        end
      end
      for (i = 0; i < 4; i = i + 2) begin
        if (nmi && fullMode[i / 2]) begin
          ctrl[i][`DBPC_BIT_MEN] <= 1'b0;
        end
      end
    end
  end

  // readback mux
  // unmapped addresses read as zero
  // status shows pending bits and the sequencer state
  always @* begin
    next_rd = 32'h00000000;
    if (wbAdr == `DBPC_OFF_MODE) begin
      next_rd = {30'h00000000, fullMode};
    end else if (wbAdr == `DBPC_OFF_STATUS) begin
      next_rd = {24'h000000, pending, 1'b0, state};
    end else if (wbAdr[7:4] == 4'h0) begin
      next_rd = {24'h000000, ctrl[wbAdr[3:2]]};
    end else if (wbAdr >= `DBPC_OFF_COUNT0A && wbAdr <= `DBPC_OFF_COUNT1B) begin
      next_rd = {16'h0000, count[cntIdx]};
    end
  end

  // wishbone ack, one cycle after the strobe, unmapped reads zero
  // read data is registered every cycle so it stands with ack;
  // a held strobe gets one ack, then a gap
  always @(posedge clk) begin
    if (!nrst) begin
      wbAck  <= 1'b0;
      wbDatR <= 32'h00000000;
    end else begin
      wbAck  <= wbCyc && wbStb && !wbAck;
      wbDatR <= next_rd;
    end
  end

  // end-of-transfer interrupts, independent of master enable
  // the lines are plain levels from the enables; the interrupt
  // controller ranks them 0a, 0b, 1a, 1b
  // b lines are masked while their pair runs in full mode
  assign end_irq_ch0_a = !ctrl[0][`DBPC_BIT_CHEN] && ctrl[0][`DBPC_BIT_IRQEN];
  assign end_irq_ch0_b = !ctrl[1][`DBPC_BIT_CHEN] && ctrl[1][`DBPC_BIT_IRQEN] && !fullMode[0];
  assign end_irq_ch1_a = !ctrl[2][`DBPC_BIT_CHEN] && ctrl[2][`DBPC_BIT_IRQEN];
  assign end_irq_ch1_b = !ctrl[3][`DBPC_BIT_CHEN] && ctrl[3][`DBPC_BIT_IRQEN] && !fullMode[1];

endmodule

/* File: bench/dbpc_checker.sv */
// port assertions for the dma bus-cycle and priority block
`timescale 1ns/10ps
module dbpc_checker (
  // watched ports
  input wire       clk, nrst, standby, busRequest, cycDead, cycRead, cycWrite, cycDone,
  input wire       refreshRequest, higherMasterReq, external_bus_request_n,
  input wire [3:0] internalReq, internalReqToCpu
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // one dead state, then the read
  property p_dead; cycDead |=> !cycDead && cycRead; endproperty
  a_dead: assert property (p_dead) else $error("dead state not followed by read");
  property p_pair; cycRead && cycDone |=> cycWrite; endproperty
  a_pair: assert property (p_pair) else $error("read not followed by write");
  property p_hold; cycRead || cycWrite |-> busRequest; endproperty
  a_hold: assert property (p_hold) else $error("bus dropped inside a pair");
  property p_wait; $rose(busRequest) |-> !cycDead [*4]; endproperty
  a_wait: assert property (p_wait) else $error("start sooner than four states");
  // yield after the current unit
  property p_refresh; cycWrite && cycDone && refreshRequest |=> !cycRead; endproperty
  a_refresh: assert property (p_refresh) else $error("refresh not given the bus");
  property p_ext; cycWrite && cycDone && !external_bus_request_n |=> !cycRead; endproperty
  a_ext: assert property (p_ext) else $error("external request not given the bus");
  property p_master; cycWrite && cycDone && higherMasterReq |=> !cycRead; endproperty
  a_master: assert property (p_master) else $error("higher master not given the bus");
  property p_stby; standby |=> !busRequest && !cycRead && !cycWrite; endproperty
  a_stby: assert property (p_stby) else $error("standby did not halt");
  property p_cpu; (internalReqToCpu & ~internalReq) == 4'h0; endproperty
  a_cpu: assert property (p_cpu) else $error("interrupt passed that was not raised");
  // main scenarios reached
  cover property (cycDead);
  cover property (cycWrite && cycDone && refreshRequest);
  cover property (standby);
endmodule

bind dbpc_core dbpc_checker chk (.*);

/* File: bench/dbpc_bus_model.sv */
// far side: cpu bus arbiter and bus controller
`timescale 1ns/10ps
module dbpc_bus_model (
  // system and bus cycles
  input wire       clk, nrst, busRequest, cycRead, cycWrite,
  input wire [7:0] gntDly,
  // answers
  output reg       busGrant, cycDone
);
  reg [7:0] waitCnt;
  // grant after a settable delay, withdraw once the bus is released
  always @(posedge clk) begin
    if (!nrst || !busRequest) begin
      waitCnt <= 8'h00;
      busGrant <= 1'b0;
    end else if (waitCnt < gntDly)
      waitCnt <= waitCnt + 8'h01;
    else
      busGrant <= 1'b1;
  end
  // each access takes two states
  always @(posedge clk) cycDone <= nrst && (cycRead || cycWrite) && !cycDone;
endmodule

/* File: bench/dma_bus_cycle_priority_control_bench.sv */
// self-checking bench for the dma bus-cycle and priority block
`timescale 1ns/10ps
`include "dbpc_defines.vh"
module dma_bus_cycle_priority_control_bench;
  reg         clk = 1'b0, nrst = 1'b0, standby = 1'b0, nmi = 1'b0;
  reg         wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, refreshRequest = 1'b0;
  reg         higherMasterReq = 1'b0, external_bus_request_n = 1'b1;
  reg  [7:0]  wbAdr = 8'h00, gntDly = 8'h01, a;
  reg  [31:0] wbDatW = 32'h0, rd;
  reg  [3:0]  transferRequest_n = 4'hF, internalReq = 4'h0;
  wire [31:0] wbDatR;
  wire [3:0]  toCpu, irq;
  wire [1:0]  cycChannel;
  wire        wbAck, busRequest, busGrant, cycRead, cycWrite, cycDead, cycDone, tEnd_n;
  integer     mismatches = 0, tests_run = 0, cycles = 0, writes = 0, base, ends = 0;
  reg  [1:0]  chLog [$];
  always #5 clk = ~clk;
  dbpc_core dut (.clk(clk), .nrst(nrst), .standby(standby), .nmi(nmi), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(4'hF), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
    .transferRequest_n(transferRequest_n), .internalReq(internalReq), .internalReqToCpu(toCpu),
    .internalReqTaken(), .busRequest(busRequest), .busGrant(busGrant),
    .external_bus_request_n(external_bus_request_n), .refreshRequest(refreshRequest),
    .higherMasterReq(higherMasterReq), .cycRead(cycRead), .cycWrite(cycWrite), .cycDead(cycDead),
    .cycChannel(cycChannel), .cycDone(cycDone), .transferEnd_n(tEnd_n), .end_irq_ch0_a(irq[0]),
    .end_irq_ch0_b(irq[1]), .end_irq_ch1_a(irq[2]), .end_irq_ch1_b(irq[3]));
  dbpc_bus_model far (.clk(clk), .nrst(nrst), .busRequest(busRequest), .cycRead(cycRead),
    .cycWrite(cycWrite), .gntDly(gntDly), .busGrant(busGrant), .cycDone(cycDone));
  // count writes, log channels at dead states, cut a hang short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycWrite && cycDone) writes <= writes + 1;
    if (cycWrite && cycDone && !tEnd_n) ends <= ends + 1;
    if (cycDead) chLog.push_back(cycChannel);
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      report_and_stop;
    end
  end
  task report_and_stop;
    begin
      $display("compares %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // one classic wishbone cycle, held until ack
  task wb(input we, input [7:0] adr, input [31:0] dat);
    begin
      @(posedge clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbDatW <= dat;
      do @(posedge clk); while (wbAck !== 1'b1);
      rd = wbDatR;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
    end
  endtask
  // wait for n writes past base, then let stray ones show
  task waitWrites(input integer n);
    begin
      repeat (3000) if (writes < base + n) @(posedge clk);
      repeat (30) @(posedge clk);
      check(writes - base, n);
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    internalReq <= 4'hF;
    wb(1'b0, 8'h30, 32'h0);
    check(rd, 32'h0);
    check(irq, 4'h0);
    check(tEnd_n, 1'b1);
    check(toCpu, 4'hF);
    for (a = 8'h00; a < 8'h10; a = a + 8'h04) wb(1'b1, a, 32'h4);
    check(irq, 4'hF);
    wb(1'b1, `DBPC_OFF_MODE, 32'h1);
    check(irq, 4'hD);
    wb(1'b1, `DBPC_OFF_MODE, 32'h3);
    check(irq, 4'h5);
    wb(1'b1, `DBPC_OFF_MODE, 32'h0);
    // level request on 0B for two units
    base = writes;
    wb(1'b1, `DBPC_OFF_COUNT0B, 32'h2);
    transferRequest_n <= 4'hD;
    wb(1'b1, `DBPC_OFF_CTRL0B, 32'h1D);
    waitWrites(2);
    check(ends, 32'h1);
    wb(1'b0, `DBPC_OFF_CTRL0B, 32'h0);
    check(rd, 32'h1C);
    check(irq[1], 1'b1);
    // 1B then 0B asked while the grant is slow
    chLog.delete();
    base = writes;
    gntDly <= 8'd40;
    wb(1'b1, `DBPC_OFF_COUNT0B, 32'h1);
    wb(1'b1, `DBPC_OFF_COUNT1B, 32'h1);
    transferRequest_n <= 4'h5;
    wb(1'b1, `DBPC_OFF_CTRL1B, 32'h1D);
    wb(1'b1, `DBPC_OFF_CTRL0B, 32'h1D);
    waitWrites(2);
    check(chLog[0], 2'h1);
    check(chLog[1], 2'h3);
    transferRequest_n <= 4'hF;
    // full-mode burst of three with the bus wanted by others
    base = writes;
    chLog.delete();
    gntDly <= 8'h01;
    refreshRequest <= 1'b1;
    higherMasterReq <= 1'b1;
    external_bus_request_n <= 1'b0;
    wb(1'b1, `DBPC_OFF_MODE, 32'h1);
    wb(1'b1, `DBPC_OFF_COUNT0A, 32'h3);
    wb(1'b1, `DBPC_OFF_CTRL0A, 32'h27);
    waitWrites(3);
    check(chLog.size(), 3);
    check(irq[1:0], 2'h1);
    refreshRequest <= 1'b0;
    higherMasterReq <= 1'b0;
    external_bus_request_n <= 1'b1;
    // the same burst alone keeps the bus: one dead state only
    base = writes;
    chLog.delete();
    wb(1'b1, `DBPC_OFF_COUNT0A, 32'h3);
    wb(1'b1, `DBPC_OFF_CTRL0A, 32'h27);
    waitWrites(3);
    check(chLog.size(), 1);
    // nmi before the start suspends, master enable resumes
    base = writes;
    wb(1'b1, `DBPC_OFF_COUNT0A, 32'h2);
    wb(1'b1, `DBPC_OFF_CTRL0A, 32'h27);
    nmi <= 1'b1;
    @(posedge clk);
    nmi <= 1'b0;
    waitWrites(0);
    wb(1'b0, `DBPC_OFF_CTRL0A, 32'h0);
    check(rd, 32'h25);
    wb(1'b1, `DBPC_OFF_CTRL0A, 32'h27);
    waitWrites(2);
    wb(1'b0, `DBPC_OFF_CTRL0A, 32'h0);
    check(rd, 32'h26);
    // standby initializes
    @(posedge clk);
    standby <= 1'b1;
    @(posedge clk);
    standby <= 1'b0;
    wb(1'b0, `DBPC_OFF_CTRL0A, 32'h0);
    check(rd, `DBPC_CTRL_RESET);
    report_and_stop;
  end
endmodule
